// >>> rtl/acs_params.svh
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ==========================================================
// Timing counts in convert-clock cycles.
`define ACS_REQ_MIN_CYC 2
`define ACS_CAL_TOTAL_CYC 32775
`define ACS_LATENCY_CYC 7
`define ACS_CAL_BUSY_CYC (`ACS_CAL_TOTAL_CYC - `ACS_LATENCY_CYC)
`define ACS_POWERON_LOG2 21
`define ACS_POWERON_CYC (1 << `ACS_POWERON_LOG2)

// ==========================================================
// Widths and strap codes.
`define ACS_DATA_W 14
`define ACS_CNT_W 22
`define ACS_STRAP_REF 2'h0
`define ACS_STRAP_GND 2'h1
`define ACS_STRAP_SUP 2'h2
`define ACS_CORR_RST 16'h0000

`endif

// >>> rtl/acs_pkg.sv
package acs_pkg;
	// Top sequencer states.
	typedef enum logic [2:0] {
		ACS_ST_POWERON,
		ACS_ST_IDLE,
		ACS_ST_REQ,
		ACS_ST_CAL,
		ACS_ST_LAT
	} acs_state_t;

	// Decoded reference range.
	typedef enum logic [1:0] {
		ACS_RANGE_2VPP,
		ACS_RANGE_4VPP,
		ACS_RANGE_EXT
	} acs_range_t;
endpackage : acs_pkg

// >>> rtl/acs_sync.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Two-flop synchroniser for one pin level.
module acs_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic pin_in,
	output logic pin_sync
);
	logic meta_q;
	logic sync_q;

	// The first stage is read by the second stage only.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	assign pin_sync = sync_q;
endmodule : acs_sync
`default_nettype wire

// >>> rtl/acs_strap.sv
`timescale 1ns/100ps
`default_nettype none
`include "acs_params.svh"
// ==========================================================
// Range strap decoder; strap code comes from the pin sense comparators.
module acs_strap
	import acs_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [1:0] strap_code,
	output acs_pkg::acs_range_t range_sel,
	output logic int_ref_en,
	output logic ref_buf_conn
);
	acs_range_t range_q;
	acs_range_t range_d;

	// Decode each cycle; unknown codes fall back to the external mode.
	always_comb begin
		unique case (strap_code)
			`ACS_STRAP_REF: range_d = ACS_RANGE_2VPP;
			`ACS_STRAP_GND: range_d = ACS_RANGE_4VPP;
			default: range_d = ACS_RANGE_EXT;
		endcase
	end

	// Registered after reset release, so the strap is never loaded asynchronously.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			range_q <= ACS_RANGE_EXT;
		end else begin
			range_q <= range_d;
		end
	end

	assign range_sel = range_q;
	assign int_ref_en = (range_q != ACS_RANGE_EXT);
	assign ref_buf_conn = (range_q != ACS_RANGE_EXT);
endmodule : acs_strap
`default_nettype wire

// >>> rtl/acs_seq.sv
// Function
// - Clear correction registers on request rising edge.
// - Start calibration on request falling edge.
// - Finish calibration within 32775 cycles total.
// - Busy flag high throughout calibration.
// - Output bus forced zero during calibration.
// - Analog inputs disabled during calibration.
// - Busy flag low when calibration completes.
// - First valid word seven cycles after busy.
// - Power-on delay of 2^21 cycles, self-calibrate.
// - Decode range strap: 2Vpp, 4Vpp, external.
`timescale 1ns/100ps
`default_nettype none
`include "acs_params.svh"
module acs_seq
	import acs_pkg::*;
#(
	parameter int unsigned POWERON_CYC = `ACS_POWERON_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cal_req,
	input wire logic [1:0] strap_code,
	input wire logic [13:0] conv_data,
	output logic cal_busy,
	output logic [13:0] data_out,
	output logic data_valid,
	output logic ain_en,
	output logic ain_n_en,
	output logic corr_clear,
	output logic [15:0] corr_reg,
	output acs_pkg::acs_range_t range_sel,
	output logic int_ref_en,
	output logic ref_buf_conn
);
	import acs_pkg::*;

	localparam int unsigned CNT_W = `ACS_CNT_W;
	localparam logic [CNT_W-1:0] BUSY_LAST = CNT_W'(`ACS_CAL_BUSY_CYC - 1);
	localparam logic [CNT_W-1:0] LAT_LAST = CNT_W'(`ACS_LATENCY_CYC - 1);
	localparam logic [CNT_W-1:0] PON_LAST = CNT_W'(POWERON_CYC - 1);

	// ==========================================================
	// Pin input conditioning.
	logic req_s;
	logic req_prev_q;
	logic req_prev_d;
	logic req_rise;
	logic req_fall;

	acs_sync u_req_sync (
		.clk(clk),
		.rstn(rstn),
		.pin_in(cal_req),
		.pin_sync(req_s)
	);

	always_comb begin
		req_prev_d = req_s;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			req_prev_q <= 1'b0;
		end else begin
			req_prev_q <= req_prev_d;
		end
	end

	assign req_rise = req_s && !req_prev_q;
	assign req_fall = !req_s && req_prev_q;

	// ==========================================================
	// Strap decoder.
	logic [1:0] strap_s;
	genvar gi;

	// The strap is a pin outside the clock domain, so each bit passes two flops.
	generate
		for (gi = 0; gi < 2; gi++) begin : g_strap_sync
			acs_sync u_strap_sync (
				.clk(clk),
				.rstn(rstn),
				.pin_in(strap_code[gi]),
				.pin_sync(strap_s[gi])
			);
		end
	endgenerate

	acs_strap u_strap (
		.clk(clk),
		.rstn(rstn),
		.strap_code(strap_s),
		.range_sel(range_sel),
		.int_ref_en(int_ref_en),
		.ref_buf_conn(ref_buf_conn)
	);

	// ==========================================================
	// Sequencer state and counter.
	acs_state_t state_q;
	acs_state_t state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [15:0] corr_q;
	logic [15:0] corr_d;
	logic clear_q;
	logic clear_d;

	// A new rising edge always restarts the request, even mid-calibration,
	// since the correction state is thrown away at that moment anyway.
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		corr_d = corr_q;
		clear_d = 1'b0;
		if (req_rise) begin
			state_d = ACS_ST_REQ;
			corr_d = `ACS_CORR_RST;
			clear_d = 1'b1;
			cnt_d = '0;
		end else begin
			unique case (state_q)
				ACS_ST_POWERON: begin
					if (cnt_q == PON_LAST) begin
						state_d = ACS_ST_CAL;
						cnt_d = '0;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				ACS_ST_IDLE: begin
					cnt_d = '0;
				end
				ACS_ST_REQ: begin
					if (req_fall) begin
						state_d = ACS_ST_CAL;
						cnt_d = '0;
					end
				end
				ACS_ST_CAL: begin
					corr_d = corr_q + 16'h0001;
					if (cnt_q == BUSY_LAST) begin
						state_d = ACS_ST_LAT;
						cnt_d = '0;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				ACS_ST_LAT: begin
					if (cnt_q == LAT_LAST) begin
						state_d = ACS_ST_IDLE;
						cnt_d = '0;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ACS_ST_POWERON;
			cnt_q <= '0;
			corr_q <= `ACS_CORR_RST;
			clear_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			corr_q <= corr_d;
			clear_q <= clear_d;
		end
	end

	// ==========================================================
	// Outputs.
	logic [13:0] dout_q;
	logic [13:0] dout_d;
	logic busy_q;
	logic busy_d;
	logic valid_q;
	logic valid_d;

	// Busy covers power-on wait too, since the inputs are not yet usable.
	always_comb begin
		busy_d = (state_d == ACS_ST_CAL) || (state_d == ACS_ST_REQ) ||
			(state_d == ACS_ST_POWERON);
		valid_d = (state_d == ACS_ST_IDLE);
		dout_d = valid_d ? conv_data : '0;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy_q <= 1'b1;
			valid_q <= 1'b0;
			dout_q <= '0;
		end else begin
			busy_q <= busy_d;
			valid_q <= valid_d;
			dout_q <= dout_d;
		end
	end

	assign cal_busy = busy_q;
	assign data_out = dout_q;
	assign data_valid = valid_q;
	assign ain_en = !busy_q;
	assign ain_n_en = !busy_q;
	assign corr_clear = clear_q;
	assign corr_reg = corr_q;

	// ==========================================================
	// Checks.
	sequence s_busy_fall;
		$fell(cal_busy);
	endsequence

	property p_rise_clear;
		@(posedge clk) disable iff (!rstn) req_rise |=> corr_clear && corr_reg == 16'h0000;
	endproperty
	a_rise_clear: assert property (p_rise_clear) else $error("corrections not cleared");

	property p_hold_high;
		@(posedge clk) disable iff (!rstn) (state_q == ACS_ST_REQ && req_s) |=> state_q == ACS_ST_REQ;
	endproperty
	a_hold_high: assert property (p_hold_high) else $error("calibration began while high");

	property p_fall_start;
		@(posedge clk) disable iff (!rstn)
			(state_q == ACS_ST_REQ && req_fall) |=> state_q == ACS_ST_CAL && cnt_q == 0;
	endproperty
	a_fall_start: assert property (p_fall_start) else $error("no start on fall");

	property p_cal_len;
		@(posedge clk) disable iff (!rstn)
			(state_q == ACS_ST_CAL && cnt_q == BUSY_LAST && !req_rise) |=> state_q == ACS_ST_LAT;
	endproperty
	a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");

	property p_busy_hi;
		@(posedge clk) disable iff (!rstn) state_q == ACS_ST_CAL |-> cal_busy;
	endproperty
	a_busy_hi: assert property (p_busy_hi) else $error("busy low in calibration");

	property p_zero_out;
		@(posedge clk) disable iff (!rstn) cal_busy |-> data_out == 14'h0000 && !data_valid;
	endproperty
	a_zero_out: assert property (p_zero_out) else $error("outputs not zero");

	property p_inputs_off;
		@(posedge clk) disable iff (!rstn) cal_busy |-> !ain_en && !ain_n_en;
	endproperty
	a_inputs_off: assert property (p_inputs_off) else $error("inputs enabled");

	property p_busy_low;
		@(posedge clk) disable iff (!rstn) state_q == ACS_ST_LAT |-> !cal_busy;
	endproperty
	a_busy_low: assert property (p_busy_low) else $error("busy high after calibration");

	property p_latency;
		@(posedge clk) disable iff (!rstn)
			s_busy_fall ##0 !req_rise [*7] |=> data_valid;
	endproperty
	a_latency: assert property (p_latency) else $error("valid data not after seven");

	property p_pon;
		@(posedge clk) disable iff (!rstn)
			(state_q == ACS_ST_POWERON && cnt_q == PON_LAST && !req_rise) |=> state_q == ACS_ST_CAL;
	endproperty
	a_pon: assert property (p_pon) else $error("no power-on calibration");

	property p_clear_pulse;
		@(posedge clk) disable iff (!rstn) corr_clear |=> !corr_clear;
	endproperty
	a_clear_pulse: assert property (p_clear_pulse) else $error("clear not one cycle");

	property p_valid_wait;
		@(posedge clk) disable iff (!rstn) s_busy_fall |-> !data_valid [*7];
	endproperty
	a_valid_wait: assert property (p_valid_wait) else $error("valid data too early");

	property p_strap_sup;
		@(posedge clk) disable iff (!rstn)
			strap_s == `ACS_STRAP_SUP |=> range_sel == ACS_RANGE_EXT && !int_ref_en && !ref_buf_conn;
	endproperty
	a_strap_sup: assert property (p_strap_sup) else $error("reference not shut down");
endmodule : acs_seq
`default_nettype wire

// >>> tb/acs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Host controller model that drives the calibration request pin.
module acs_host_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic [15:0] width,
	output logic cal_req
);
	logic [15:0] left_q;
	logic [15:0] left_d;
	// minimum pulse width
	// Short widths are stretched to two cycles, since shorter pulses are undefined.
	always_comb begin
		left_d = left_q;
		if (start) begin
			left_d = (width < 16'h0002) ? 16'h0002 : width;
		end else if (left_q != 16'h0000) begin
			left_d = left_q - 16'h0001;
		end
	end
	// clock kept running
	// The model only counts edges and never gates the convert clock.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			left_q <= 16'h0000;
		end else begin
			left_q <= left_d;
		end
	end
	assign cal_req = (left_q != 16'h0000);
endmodule : acs_host_model
`default_nettype wire

// >>> tb/acs_seq_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Bench for the calibration sequencer.
module acs_seq_tb;
	import acs_pkg::*;
	localparam int POW = 64;
	localparam int CAL = 32768;
	logic clk, rstn, start, cal_req, cal_busy, data_valid, ain_en, ain_n_en;
	logic corr_clear, int_ref_en, ref_buf_conn;
	logic [15:0] width, corr_reg;
	logic [1:0] strap_code;
	logic [13:0] conv_data, data_out;
	acs_range_t range_sel;
	int n_mismatch, checked, seed, n, lat, i;
	int exp_q[$];

	acs_seq #(.POWERON_CYC(POW)) dut_u (.clk(clk), .rstn(rstn), .cal_req(cal_req),
		.strap_code(strap_code), .conv_data(conv_data), .cal_busy(cal_busy),
		.data_out(data_out), .data_valid(data_valid), .ain_en(ain_en), .ain_n_en(ain_n_en),
		.corr_clear(corr_clear), .corr_reg(corr_reg), .range_sel(range_sel),
		.int_ref_en(int_ref_en), .ref_buf_conn(ref_buf_conn));
	acs_host_model host_u (.clk(clk), .rstn(rstn), .start(start), .width(width),
		.cal_req(cal_req));

	// ==========================================================
	// Clock, checking and closing.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] expv);
		checked++;
		if (seen !== expv) begin
			n_mismatch++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, expv);
		end
	endtask : check
	task automatic end_of_test();
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	task automatic step();
		@(posedge clk);
		#1;
	endtask : step
	// Outputs stay blanked every busy cycle; a hang past the bound ends the run.
	task automatic wait_idle(output int cnt);
		cnt = 0;
		while (cal_busy !== 1'b0) begin
			check({data_out, ain_en, ain_n_en}, 16'h0000);
			step();
			cnt++;
			if (cnt > 40000) begin
				n_mismatch++;
				end_of_test();
			end
		end
	endtask : wait_idle
	// Busy falls, then the first valid word must come exactly seven edges later.
	task automatic check_latency();
		lat = 0;
		while (data_valid !== 1'b1 && lat < 20) begin
			step();
			lat++;
		end
		check(16'(lat), 16'h0007);
		check({2'h0, data_out}, {2'h0, conv_data});
	endtask : check_latency

	// ==========================================================
	// Main sequence.
	initial begin
		seed = 16;
		rstn = 1'b0;
		start = 1'b0;
		width = 16'h0002;
		strap_code = 2'h0;
		conv_data = 14'h0000;
		repeat (16) step();
		check({cal_busy, data_valid, ain_en, 13'h0}, 16'h8000);
		@(posedge clk);
		rstn <= 1'b1;
		for (i = 0; i < 4; i++) begin
			exp_q.push_back((i == 0) ? 16'h0003 : (i == 1) ? 16'h0007 : 16'h0008);
			strap_code <= 2'(i);
			repeat (3) step();
			check({12'h0, range_sel, int_ref_en, ref_buf_conn}, exp_q.pop_front());
		end
		conv_data <= 14'($random(seed));
		wait_idle(n);
		n = n + 13;
		check(16'((n >= POW + CAL) && (n <= POW + CAL + 4)), 16'h0001);
		check_latency();
		for (i = 0; i < 8; i++) begin
			conv_data <= 14'($random(seed));
			repeat (4) step();
			check({1'b0, data_valid, data_out}, {2'h1, conv_data});
		end
		@(posedge clk);
		start <= 1'b1;
		width <= 16'h0002;
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		while (corr_clear !== 1'b1 && n < 8) begin
			step();
			n++;
		end
		check({corr_clear, cal_busy, corr_reg[13:0]}, 16'hc000);
		repeat (1000) step();
		@(posedge clk);
		start <= 1'b1;
		width <= 16'h00c8;
		@(posedge clk);
		start <= 1'b0;
		repeat (200) step();
		check({15'h0, cal_busy}, 16'h0001);
		n = 0;
		while (cal_req !== 1'b0 && n < 300) begin
			step();
			n++;
		end
		wait_idle(n);
		check(16'((n >= CAL) && (n <= CAL + 5)), 16'h0001);
		check_latency();
		check(16'(n + lat <= CAL + 12), 16'h0001);
		end_of_test();
	end
endmodule : acs_seq_tb
`default_nettype wire
